// [pkg/cri_pkg.sv]
package cri_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] TIMER_CTRL_OFF = 8'h00;
	localparam logic [ADDR_W-1:0] TIMER_STAT_OFF = 8'h04;
	localparam logic [ADDR_W-1:0] DEBUG_CTRL0_OFF = 8'h08;
	localparam logic [ADDR_W-1:0] RESET_CFG_OFF = 8'h0c;
	localparam logic [ADDR_W-1:0] RESET_STAT_OFF = 8'h10;
	localparam logic [ADDR_W-1:0] PC_OFF = 8'h14;
	localparam logic [1:0] WRC_RESET = 2'h0;
	localparam logic [19:0] EPN_RESET = 20'hfffff;
	localparam logic [1:0] RPN_LOW_RESET = 2'h0;
	localparam logic [3:0] SIZE_4KB = 4'h1;
	localparam logic [7:0] TID_RESET = 8'h00;
	localparam logic [31:0] PC_RESET = 32'hfffffffc;
	localparam int CLK_PERIOD_NS = 100;
	localparam int RESET_HOLD_NS = 1000;
	localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(RESET_HOLD_CYC);
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

	typedef enum logic [1:0] {
		RT_NONE = 2'h0,
		RT_CORE = 2'h1,
		RT_CHIP = 2'h2,
		RT_SYSTEM = 2'h3
	} cri_rtype_type;

	typedef enum logic [2:0] {
		SRC_NONE = 3'h0,
		SRC_PIN = 3'h1,
		SRC_WDOG = 3'h2,
		SRC_DEBUG = 3'h3,
		SRC_JTAG = 3'h4,
		SRC_POWER = 3'h5
	} cri_src_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_HOLD = 3'b010,
		ST_RELEASE = 3'b100
	} cri_state_type;

	typedef struct packed {
		logic [3:0] user_attrs;
		logic endian;
		logic [3:0] config_ext_page_number;
	} cri_strap_type;

	typedef struct packed {
		logic valid;
		logic [19:0] effective_page_number;
		logic translation_space;
		logic [3:0] size;
		logic [7:0] translation_id;
		logic [21:0] real_page_number;
		logic [3:0] extended_real_page_number;
		logic [3:0] user_attrs;
		logic write_through;
		logic cache_inhibit;
		logic mem_coherent;
		logic guarded;
		logic endian;
		logic sup_exec_perm;
		logic sup_write_perm;
		logic sup_read_perm;
	} cri_shadow_type;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [ADDR_W-1:0] adr;
		logic [3:0] sel;
		logic [DATA_W-1:0] dat;
	} cri_wb_req_type;

	typedef struct packed {
		logic ack;
		logic [DATA_W-1:0] dat;
	} cri_wb_rsp_type;
endpackage

// [core/cri_core_reset_init.sv]
`timescale 1ns/1ps
module cri_core_reset_init import cri_pkg::*; (
	input wire logic core_clk,
	input wire logic rst,
	input wire cri_wb_req_type wb_req,
	output cri_wb_rsp_type wb_rsp,
	input wire logic core_rst_req_pin,
	input wire logic chip_rst_req_pin,
	input wire logic sys_rst_req_pin,
	input wire logic jtag_rst_req,
	input wire logic [1:0] jtag_rst_type,
	input wire logic wdog_expire,
	input wire cri_strap_type strap,
	input wire logic ctx_sync,
	input wire logic [31:0] fetch_ea,
	input wire logic [31:0] data_ea,
	output logic core_reset,
	output logic chip_reset,
	output logic system_reset_out,
	output logic boot_start,
	output logic [31:0] program_counter,
	output cri_strap_type reset_config_reg,
	output cri_shadow_type shadow_entry,
	output logic boot_fetch_ok,
	output logic boot_read_ok
);
	// Async inputs: pins, JTAG and straps
	localparam int SYNC_W = 6 + $bits(cri_strap_type);

	logic [SYNC_W-1:0] sync1_q;
	logic [SYNC_W-1:0] sync2_q;
	logic [SYNC_W-1:0] sync_d;
	logic core_req_s;
	logic chip_req_s;
	logic sys_req_s;
	logic jtag_req_s;
	logic [1:0] jtag_type_s;
	cri_strap_type strap_s;

	cri_state_type state_q;
	cri_state_type state_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	cri_rtype_type type_q;
	cri_rtype_type type_d;
	cri_src_type src_q;
	cri_src_type src_d;
	logic [1:0] wrc_q;
	logic [1:0] wrc_d;
	logic [1:0] wrs_q;
	logic [1:0] wrs_d;
	cri_strap_type cfg_q;
	cri_strap_type cfg_d;
	cri_shadow_type shadow_q;
	cri_shadow_type shadow_d;
	logic core_rst_q;
	logic chip_rst_q;
	logic sys_rst_q;
	logic boot_q;
	logic core_rst_d;
	logic chip_rst_d;
	logic sys_rst_d;
	logic boot_d;
	logic fetch_ok_q;
	logic read_ok_q;
	logic fetch_ok_d;
	logic read_ok_d;
	logic ack_q;
	logic ack_d;
	logic [DATA_W-1:0] rdat_q;
	logic [DATA_W-1:0] rdat_d;

	logic bus_acc;
	logic bus_wr;
	cri_rtype_type pin_type;
	cri_rtype_type req_type;
	cri_src_type req_src;
	logic dbg_req;
	logic wd_req;
	logic level_req;
	cri_shadow_type shadow_init;

	function automatic cri_rtype_type rt_max(input cri_rtype_type a, input cri_rtype_type b);
		rt_max = (a > b) ? a : b;
	endfunction

	// Each async request passes two flops before any logic sees it
	assign sync_d = {core_rst_req_pin, chip_rst_req_pin, sys_rst_req_pin, jtag_rst_req, jtag_rst_type, strap};

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= sync_d;
			sync2_q <= sync1_q;
		end
	end

	assign {core_req_s, chip_req_s, sys_req_s, jtag_req_s, jtag_type_s, strap_s} = sync2_q;

	// Wishbone classic: ack one cycle after the request, write at the acked edge
	assign bus_acc = wb_req.cyc && wb_req.stb;
	assign bus_wr = bus_acc && wb_req.we && ack_q;

	// One dedicated pin per reset type; the widest type wins
	always_comb begin
		if (sys_req_s) begin
			pin_type = RT_SYSTEM;
		end else if (chip_req_s) begin
			pin_type = RT_CHIP;
		end else if (core_req_s) begin
			pin_type = RT_CORE;
		end else begin
			pin_type = RT_NONE;
		end
	end

	assign wd_req = wdog_expire && (wrc_q != WRC_RESET);
	assign dbg_req = bus_wr && (wb_req.adr == DEBUG_CTRL0_OFF) && wb_req.sel[0]
		&& (wb_req.dat[1:0] != RT_NONE);
	assign level_req = (pin_type != RT_NONE) || jtag_req_s;

	always_comb begin
		req_type = RT_NONE;
		req_src = SRC_NONE;
		if (pin_type != RT_NONE) begin
			req_type = pin_type;
			req_src = SRC_PIN;
		end
		if (jtag_req_s) begin
			// A JTAG request with no type given still resets the core
			req_src = (req_type == RT_NONE) ? SRC_JTAG : req_src;
			req_type = rt_max(req_type, (jtag_type_s == RT_NONE) ? RT_CORE : cri_rtype_type'(jtag_type_s));
		end
		if (wd_req) begin
			req_src = (req_type == RT_NONE) ? SRC_WDOG : req_src;
			req_type = rt_max(req_type, cri_rtype_type'(wrc_q));
		end
		if (dbg_req) begin
			req_src = (req_type == RT_NONE) ? SRC_DEBUG : req_src;
			req_type = rt_max(req_type, cri_rtype_type'(wb_req.dat[1:0]));
		end
	end

	// Boot page entry; same values for every reset type
	always_comb begin
		shadow_init = '0;
		shadow_init.valid = 1'b1;
		shadow_init.effective_page_number = EPN_RESET;
		shadow_init.translation_space = 1'b0;
		shadow_init.size = SIZE_4KB;
		shadow_init.translation_id = TID_RESET;
		shadow_init.real_page_number = {EPN_RESET, RPN_LOW_RESET};
		shadow_init.extended_real_page_number = strap_s.config_ext_page_number;
		shadow_init.user_attrs = strap_s.user_attrs;
		shadow_init.endian = strap_s.endian;
		shadow_init.write_through = 1'b0;
		shadow_init.mem_coherent = 1'b0;
		shadow_init.cache_inhibit = 1'b1;
		shadow_init.guarded = 1'b1;
		shadow_init.sup_exec_perm = 1'b1;
		shadow_init.sup_read_perm = 1'b1;
		shadow_init.sup_write_perm = 1'b0;
	end

	// Sequencer and reset-state loading
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		type_d = type_q;
		src_d = src_q;
		wrc_d = wrc_q;
		wrs_d = wrs_q;
		cfg_d = cfg_q;
		shadow_d = shadow_q;
		boot_d = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (req_type != RT_NONE) begin
					state_d = ST_HOLD;
					cnt_d = HOLD_LOAD;
					type_d = req_type;
					src_d = req_src;
					if (wd_req) begin
						wrs_d = wrc_q;
					end
				end else begin
					if (bus_wr && wb_req.adr == TIMER_CTRL_OFF && wb_req.sel[0]) begin
						wrc_d = wb_req.dat[1:0];
					end
					if (ctx_sync) begin
						shadow_d.valid = 1'b0;
					end
				end
			end
			ST_HOLD: begin
				// Straps and reset values are reloaded every held cycle, so late straps still land
				wrc_d = WRC_RESET;
				cfg_d = strap_s;
				shadow_d = shadow_init;
				type_d = rt_max(type_q, req_type);
				if (level_req) begin
					cnt_d = HOLD_LOAD;
				end else if (cnt_q == CNT_ONE || cnt_q == CNT_ZERO) begin
					cnt_d = CNT_ZERO;
					state_d = ST_RELEASE;
				end else begin
					cnt_d = cnt_q - CNT_ONE;
				end
			end
			ST_RELEASE: begin
				// A request on the release cycle restarts the hold, so no request pulse or debug write on that cycle is lost
				if (req_type != RT_NONE) begin
					state_d = ST_HOLD;
					cnt_d = HOLD_LOAD;
					type_d = req_type;
					src_d = req_src;
					if (wd_req) begin
						wrs_d = wrc_q;
					end
				end else begin
					boot_d = 1'b1;
					state_d = ST_IDLE;
				end
				if (ctx_sync) begin
					shadow_d.valid = 1'b0;
				end
			end
			default: begin
				state_d = ST_HOLD;
				cnt_d = HOLD_LOAD;
			end
		endcase
	end

	// Outputs per type: core always, chip for chip/system, off-chip only for system
	always_comb begin
		core_rst_d = (state_d == ST_HOLD);
		chip_rst_d = (state_d == ST_HOLD) && (type_d == RT_CHIP || type_d == RT_SYSTEM);
		sys_rst_d = (state_d == ST_HOLD) && (type_d == RT_SYSTEM);
		// Write permission is never granted, so no write path exists at all
		fetch_ok_d = shadow_d.valid && shadow_d.sup_exec_perm
			&& (fetch_ea[31:12] == shadow_d.effective_page_number);
		read_ok_d = shadow_d.valid && shadow_d.sup_read_perm
			&& (data_ea[31:12] == shadow_d.effective_page_number);
	end

	// Register read mux; the shadow entry has no address, keeping it hidden
	always_comb begin
		ack_d = bus_acc && !ack_q;
		rdat_d = rdat_q;
		if (bus_acc && !ack_q) begin
			case (wb_req.adr)
				TIMER_CTRL_OFF: rdat_d = {30'h0, wrc_q};
				TIMER_STAT_OFF: rdat_d = {30'h0, wrs_q};
				DEBUG_CTRL0_OFF: rdat_d = 32'h0;
				RESET_CFG_OFF: rdat_d = {23'h0, cfg_q};
				RESET_STAT_OFF: rdat_d = {26'h0, core_rst_q, src_q, type_q};
				PC_OFF: rdat_d = PC_RESET;
				default: rdat_d = 32'h0;
			endcase
		end
	end

	// Power-up counts as a chip-type reset that never reaches off-chip logic
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_HOLD;
			cnt_q <= HOLD_LOAD;
			type_q <= RT_CHIP;
			src_q <= SRC_POWER;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			type_q <= type_d;
			src_q <= src_d;
		end
	end

	// Shadow entry stays invalid until the hold loads it
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wrc_q <= WRC_RESET;
			wrs_q <= 2'h0;
			cfg_q <= '0;
			shadow_q <= '0;
		end else begin
			wrc_q <= wrc_d;
			wrs_q <= wrs_d;
			cfg_q <= cfg_d;
			shadow_q <= shadow_d;
		end
	end

	// Reset outputs come from flops, so the far side never sees a glitch
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			core_rst_q <= 1'b1;
			chip_rst_q <= 1'b1;
			sys_rst_q <= 1'b0;
			boot_q <= 1'b0;
		end else begin
			core_rst_q <= core_rst_d;
			chip_rst_q <= chip_rst_d;
			sys_rst_q <= sys_rst_d;
			boot_q <= boot_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			fetch_ok_q <= 1'b0;
			read_ok_q <= 1'b0;
		end else begin
			fetch_ok_q <= fetch_ok_d;
			read_ok_q <= read_ok_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ack_q <= 1'b0;
			rdat_q <= 32'h0;
		end else begin
			ack_q <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	assign wb_rsp.ack = ack_q;
	assign wb_rsp.dat = rdat_q;
	assign core_reset = core_rst_q;
	assign chip_reset = chip_rst_q;
	assign system_reset_out = sys_rst_q;
	assign boot_start = boot_q;
	assign program_counter = PC_RESET;
	assign reset_config_reg = cfg_q;
	assign shadow_entry = shadow_q;
	assign boot_fetch_ok = fetch_ok_q;
	assign boot_read_ok = read_ok_q;
endmodule // cri_core_reset_init

// [dv/cri_reset_checker.sv]
`timescale 1ns/1ps
module cri_reset_checker import cri_pkg::*; (
	input wire logic core_clk,
	input wire logic rst,
	input wire cri_wb_rsp_type wb_rsp,
	input wire cri_strap_type strap,
	input wire logic ctx_sync,
	input wire logic [31:0] fetch_ea,
	input wire logic core_reset,
	input wire logic chip_reset,
	input wire logic system_reset_out,
	input wire logic boot_start,
	input wire logic [31:0] program_counter,
	input wire cri_strap_type reset_config_reg,
	input wire cri_shadow_type shadow_entry,
	input wire logic boot_fetch_ok
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	cri_shadow_type s;
	assign s = shadow_entry;
	chk_sys_chip: assert property (system_reset_out |-> chip_reset && core_reset)
		else $error("system reset without chip reset");
	chk_chip_core: assert property (chip_reset |-> core_reset)
		else $error("chip reset without core reset");
	chk_boot_after: assert property ($fell(core_reset) |-> ##[0:1] boot_start)
		else $error("no boot pulse after reset");
	chk_boot_page: assert property (boot_start |-> s.valid && &s.effective_page_number &&
		!s.translation_space && s.size == SIZE_4KB && s.translation_id == TID_RESET)
		else $error("boot page fields wrong");
	chk_boot_map: assert property (boot_start |-> s.real_page_number == {EPN_RESET, RPN_LOW_RESET})
		else $error("boot page not identity mapped");
	chk_boot_attr: assert property (boot_start |-> {s.write_through, s.cache_inhibit,
		s.mem_coherent, s.guarded, s.sup_exec_perm, s.sup_write_perm, s.sup_read_perm} == 7'h2d)
		else $error("boot page attributes wrong");
	chk_boot_strap: assert property (boot_start |-> reset_config_reg == strap && s.endian == strap.endian &&
		s.extended_real_page_number == strap.config_ext_page_number && s.user_attrs == strap.user_attrs)
		else $error("strap copy wrong");
	chk_pc_const: assert property (program_counter == PC_RESET)
		else $error("start address wrong");
	chk_ctx_drop: assert property (ctx_sync && !core_reset |=> !s.valid || core_reset)
		else $error("shadow entry kept after sync");
	chk_fetch_ok: assert property (!core_reset && !ctx_sync && s.valid &&
		fetch_ea[31:12] == s.effective_page_number |=> boot_fetch_ok || core_reset)
		else $error("boot fetch refused");
	chk_ack_pulse: assert property (wb_rsp.ack |=> !wb_rsp.ack)
		else $error("ack longer than one cycle");
endmodule // cri_reset_checker
bind cri_core_reset_init cri_reset_checker u_chk (.*);

// [dv/cri_far_model.sv]
`timescale 1ns/1ps
module cri_far_model (
	input wire logic core_clk,
	output logic core_rst_req_pin,
	output logic chip_rst_req_pin,
	output logic sys_rst_req_pin,
	output logic jtag_rst_req,
	output logic [1:0] jtag_rst_type
);
	logic [2:0] pin_q = 3'h0;
	assign {sys_rst_req_pin, chip_rst_req_pin, core_rst_req_pin} = pin_q;
	initial jtag_rst_req = 1'b0;
	initial jtag_rst_type = 2'h0;
	// Request levels stay up four cycles, long enough to pass the two-flop synchroniser
	task automatic req(input logic [1:0] kind, input logic jtag);
		@(posedge core_clk);
		jtag_rst_type <= kind;
		if (jtag)
			jtag_rst_req <= 1'b1;
		else
			pin_q[kind - 2'h1] <= 1'b1;
		repeat (4) @(posedge core_clk);
		jtag_rst_req <= 1'b0;
		pin_q <= 3'h0;
	endtask
endmodule // cri_far_model

// [dv/cri_tb.sv]
`timescale 1ns/1ps
module tb import cri_pkg::*;;
	localparam cri_strap_type STRAP = '{user_attrs: 4'ha, endian: 1'b1, config_ext_page_number: 4'h5};
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	cri_wb_req_type wb_req = '0;
	cri_wb_rsp_type wb_rsp;
	logic core_rst_req_pin, chip_rst_req_pin, sys_rst_req_pin, jtag_rst_req;
	logic [1:0] jtag_rst_type;
	logic wdog_expire = 1'b0;
	logic ctx_sync = 1'b0;
	logic [31:0] fetch_ea = PC_RESET;
	logic core_reset, chip_reset, system_reset_out, boot_start, boot_fetch_ok, boot_read_ok;
	cri_shadow_type shadow_entry;
	logic [31:0] q;
	logic [31:0] watchdog_reset_status = 32'h0;
	int miscompares = 0;
	int compares = 0;
	int cycles = 0;
	always #50 core_clk = ~core_clk;
	cri_core_reset_init u_dut (.core_clk, .rst, .wb_req, .wb_rsp, .core_rst_req_pin, .chip_rst_req_pin,
		.sys_rst_req_pin, .jtag_rst_req, .jtag_rst_type, .wdog_expire, .strap(STRAP), .ctx_sync, .fetch_ea,
		.data_ea(PC_RESET), .core_reset, .chip_reset, .system_reset_out, .boot_start, .program_counter(),
		.reset_config_reg(), .shadow_entry, .boot_fetch_ok, .boot_read_ok);
	cri_far_model u_far (.core_clk, .core_rst_req_pin, .chip_rst_req_pin, .sys_rst_req_pin,
		.jtag_rst_req, .jtag_rst_type);
	task automatic end_of_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			miscompares++;
			end_of_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Ack is sampled at the rising edge; data is taken and the request released at that edge
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
		@(posedge core_clk);
		while (wb_rsp.ack !== 1'b1)
			@(posedge core_clk);
		q = wb_rsp.dat;
		wb_req <= '0;
	endtask
	task automatic wait_boot();
		while (boot_start !== 1'b1)
			@(negedge core_clk);
		@(negedge core_clk);
	endtask
	task automatic see_reset(input logic c, input logic s);
		while (core_reset !== 1'b1)
			@(negedge core_clk);
		repeat (3) @(negedge core_clk);
		chk(chip_reset, c);
		chk(system_reset_out, s);
		wait_boot();
	endtask
	initial begin
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		wait_boot();
		wb(1'b0, RESET_CFG_OFF, 32'h0);
		chk(q, {23'h0, STRAP});
		wb(1'b0, 8'h40, 32'h0);
		chk(q, 32'h0);
		@(posedge core_clk);
		wdog_expire <= 1'b1;
		@(posedge core_clk);
		wdog_expire <= 1'b0;
		repeat (20) @(negedge core_clk);
		chk(core_reset, 1'b0);
		for (int src = 0; src < 4; src++) begin
			for (int k = 1; k < 4; k++) begin
				if (src < 2)
					u_far.req(k[1:0], src[0]);
				else
					wb(1'b1, src == 2 ? TIMER_CTRL_OFF : DEBUG_CTRL0_OFF, 32'(k));
				if (src == 2) begin
					@(posedge core_clk);
					wdog_expire <= 1'b1;
					@(posedge core_clk);
					wdog_expire <= 1'b0;
					watchdog_reset_status = 32'(k);
				end
				see_reset(k >= 2, k == 3);
				wb(1'b0, TIMER_STAT_OFF, 32'h0);
				chk(q, watchdog_reset_status);
				wb(1'b0, TIMER_CTRL_OFF, 32'h0);
				chk(q, 32'h0);
			end
		end
		@(negedge core_clk);
		chk(boot_read_ok, 1'b1);
		@(posedge core_clk);
		ctx_sync <= 1'b1;
		@(posedge core_clk);
		ctx_sync <= 1'b0;
		@(negedge core_clk);
		chk(shadow_entry.valid, 1'b0);
		chk(boot_read_ok, 1'b0);
		end_of_test();
	end
endmodule // tb
